// ---- dv/testbench.sv ----
// Self-checking bench for the serial unit.
// Assumes one AHB-Lite master (this bench) and the remote station model.
`timescale 1ns/1ps
module testbench;
   import uartb_pkg::*;
   localparam int BAUD = 2;
   localparam int BIT = 16 * BAUD;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [AW-1:0] haddr = '0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [HW-1:0] hwdata = '0;
   logic [HW-1:0] hrdata;
   logic hreadyout, hresp, rxd, txd, irq, rx_error_irq, tx_empty_irq;
   logic [2:0] pins;
   logic [31:0] rd;
   logic [31:0] stat_e;
   logic [7:0] a, b, c;
   logic [5:0] modes [4] = '{6'h03, 6'h23, 6'h07, 6'h1F};
   int fail_count = 0;
   int n_checks = 0;
   int txi_cnt = 0;
   int base;
   assign pins = {txd, rx_error_irq, irq};
   always #25 core_clk = ~core_clk;
   uartb_top uartb_top_i (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxd, .txd, .irq,
      .rx_error_irq, .tx_empty_irq);
   uartb_remote #(.BIT_CYC(BIT)) uartb_remote_i (.core_clk, .txd, .rxd);
   always @(negedge core_clk) begin
      if (tx_empty_irq === 1'b1) begin
         txi_cnt <= txi_cnt + 1;
      end
   end
   function automatic logic par_of(input logic [7:0] d, input bit seven, input bit odd);
      return (seven ? ^d[6:0] : ^d) ^ odd;
   endfunction : par_of
   function automatic logic [31:0] rx_stat(input bit rxf, input bit ov, input bit fe,
         input bit pe);
      return {27'h0, pe, fe, ov, rxf, 1'b0};
   endfunction : rx_stat
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
      n_checks++;
      if (got !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, e, got);
      end
   endtask : chk
   task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= AW'(ad);
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : ahb
   task automatic rchk(input string what, input logic [7:0] ad, input logic [31:0] m,
         input logic [31:0] e);
      ahb(1'b0, ad, 32'h0);
      chk(what, e, rd & m);
   endtask : rchk
   task automatic pin(input string what, input int i, input logic e);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk(what, {31'h0, e}, {31'h0, pins[i]});
      @(posedge core_clk);
   endtask : pin
   task automatic frame(input logic [7:0] d, input logic [5:0] m, input bit pe, input bit fe);
      uartb_remote_i.send(d, m[C_BITS7] ? 7 : 8, m[C_PAREN],
         par_of(d, m[C_BITS7], m[C_PARODD]) ^ pe, ~fe, m[C_STOP2]);
   endtask : frame
   task automatic wait_q(input int n);
      for (int t = 0; t < 40 * BIT && uartb_remote_i.got_q.size() < n; t++) begin
         @(posedge core_clk);
      end
   endtask : wait_q
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   initial begin
      void'($urandom(8));
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      rchk("ctrl", OFF_CTRL, 32'hFF, {26'h0, CTRL_RST});
      rchk("baud", OFF_BAUD, 32'hFFFF, {16'h0, DIV_RST});
      rchk("stat", OFF_STAT, 32'h3F, 32'h21);
      rchk("imask", OFF_IMASK, 32'hFFFFFFFF, 32'h0);
      ahb(1'b1, 8'h1C, 32'hFFFFFFFF);
      rchk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
      pin("txd idle", 2, 1'b1);
      ahb(1'b1, OFF_BAUD, 32'(BAUD));
      $display("test reset finished");
      base = txi_cnt;
      a = 8'($urandom);
      b = 8'($urandom);
      c = 8'($urandom);
      rchk("tx empty", OFF_STAT, 32'h1, 32'h1);
      ahb(1'b1, OFF_TXB, {24'h0, a});
      ahb(1'b1, OFF_TXB, {24'h0, b});
      rchk("tx pending", OFF_STAT, 32'h1, 32'h0);
      ahb(1'b1, OFF_TXB, {24'h0, c});
      wait_q(2);
      repeat (2 * BIT) @(posedge core_clk);
      chk("tx count", 32'h2, 32'(uartb_remote_i.got_q.size()));
      chk("tx first", {24'h0, a}, {24'h0, uartb_remote_i.got_q[0]});
      chk("tx second", {24'h0, c}, {24'h0, uartb_remote_i.got_q[1]});
      chk("tx irq count", 32'(base + 2), 32'(txi_cnt));
      uartb_remote_i.got_q.delete();
      $display("test transmit finished");
      uartb_remote_i.hold_low(BIT / 4);
      repeat (24 * BIT) @(posedge core_clk);
      rchk("false start", OFF_STAT, 32'h1E, 32'h0);
      $display("test false start finished");
      foreach (modes[m]) begin
         a = 8'($urandom);
         ahb(1'b1, OFF_CTRL, {26'h0, modes[m]});
         frame(a, modes[m], 1'b0, 1'b0);
         rchk("rx stat", OFF_STAT, 32'h1E, rx_stat(1, 0, 0, 0));
         rchk("rx byte", OFF_RXB, 32'hFF, {24'h0, modes[m][C_BITS7] ? a & 8'h7F : a});
         pin("irq masked", 0, 1'b0);
         ahb(1'b1, OFF_IMASK, 32'h1);
         pin("irq on", 0, 1'b1);
         rchk("istat", OFF_ISTAT, 32'h1, 32'h1);
         pin("irq cleared", 0, 1'b0);
         ahb(1'b1, OFF_IMASK, 32'h0);
      end
      $display("test frame modes finished");
      ahb(1'b1, OFF_CTRL, 32'h07);
      for (int k = 1; k < 8; k++) begin
         a = 8'($urandom);
         b = 8'($urandom);
         if (k[2]) begin
            frame(a, 6'h07, 1'b0, 1'b0);
         end
         frame(b, 6'h07, k[0], k[1]);
         stat_e = rx_stat(k[2], k[2], k[1], k[0]);
         rchk("err stat", OFF_STAT, 32'h1E, stat_e);
         pin("err irq", 1, 1'b1);
         rchk("err byte", OFF_RXB, 32'hFF, {24'h0, k[2] ? a : b});
         ahb(1'b1, OFF_STAT, 32'h1C);
         pin("err irq clear", 1, 1'b0);
         rchk("err clear", OFF_STAT, 32'h1E, 32'h0);
      end
      $display("test receive errors finished");
      ahb(1'b1, OFF_CTRL, 32'h03);
      fork
         uartb_remote_i.hold_low(40 * BIT);
         begin
            repeat (12 * BIT) @(posedge core_clk);
            rchk("break stat", OFF_STAT, 32'h1E, rx_stat(0, 0, 1, 0));
            rchk("break byte", OFF_RXB, 32'hFF, 32'h0);
            a = 8'($urandom);
            ahb(1'b1, OFF_TXB, {24'h0, a});
            repeat (11 * BIT) @(posedge core_clk);
            chk("tx held", 32'h0, 32'(uartb_remote_i.got_q.size()));
            ahb(1'b1, OFF_STAT, 32'h08);
            repeat (12 * BIT) @(posedge core_clk);
            rchk("break again", OFF_STAT, 32'h1E, rx_stat(0, 0, 1, 0));
         end
      join
      ahb(1'b1, OFF_STAT, 32'h1C);
      wait_q(1);
      chk("tx resumed", {24'h0, a}, {24'h0, uartb_remote_i.got_q[0]});
      $display("test line break finished");
      test_done();
   end
   initial begin
      repeat (40000) @(posedge core_clk);
      fail_count++;
      $display("[FAIL] watchdog expected end seen timeout");
      test_done();
   end
endmodule : testbench

// ---- dv/uartb_remote.sv ----
// Remote serial station: drives the receive line and decodes transmit frames.
// Assumes core_clk timing and a bit time of BIT_CYC core cycles.
`timescale 1ns/1ps
module uartb_remote #(
   parameter int BIT_CYC = 32
) (
   input wire logic core_clk,
   input wire logic txd,
   output logic rxd
);
   logic [7:0] got_q[$];
   logic [7:0] sh;
   initial rxd = 1'b1;
   task automatic drive_bit(input logic b);
      rxd <= b;
      repeat (BIT_CYC) @(posedge core_clk);
   endtask : drive_bit
   // Start, data LSB first, parity, stop bits, one idle bit
   task automatic send(input logic [7:0] d, input int nbits, input bit par_en,
         input logic par, input logic stop, input bit two_stop);
      drive_bit(1'b0);
      for (int i = 0; i < nbits; i++) begin
         drive_bit(d[i]);
      end
      if (par_en) begin
         drive_bit(par);
      end
      drive_bit(stop);
      if (two_stop) begin
         drive_bit(1'b1);
      end
      drive_bit(1'b1);
   endtask : send
   task automatic hold_low(input int n);
      rxd <= 1'b0;
      repeat (n) @(posedge core_clk);
      rxd <= 1'b1;
   endtask : hold_low
   // Eight data bits, one stop, sampled mid bit
   always begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      if (txd === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge core_clk);
            sh[i] = txd;
         end
         repeat (BIT_CYC) @(posedge core_clk);
         if (txd === 1'b1) begin
            got_q.push_back(sh);
         end
      end
   end
endmodule : uartb_remote

// ---- hdl/uartb_baud.sv ----
// Divider making the sixteen-times sampling clock as two phase pulses.
// Assumes div is a core_clk register; values below two are raised.
`timescale 1ns/1ps
module uartb_baud (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [15:0] div,
   uartb_samp_if.tick_src samp
);
   import uartb_pkg::*;
   typedef struct packed {
      logic [15:0] cnt;
      logic rise;
      logic fall;
   } uartb_baud_s;
   uartb_baud_s q, d;
   logic [15:0] lim;

   always_comb begin
      lim = (div < DIV_MIN) ? DIV_MIN : div;
      d.cnt = (q.cnt >= lim - 16'h0001) ? 16'h0000 : q.cnt + 16'h0001;
      // Falling phase at count start, rising phase half a period later
      d.fall = (q.cnt == 16'h0000);
      d.rise = (q.cnt == (lim >> 1));
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign samp.samp_rise = q.rise;
   assign samp.samp_fall = q.fall;
endmodule : uartb_baud

// ---- hdl/uartb_pkg.sv ----
// Package: register map, field positions, reset values and state codes
// of the serial unit. Shared by the top level, the divider and the testbench.
package uartb_pkg;
   localparam int HW = 32;
   localparam int AW = 32;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_BAUD = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_TXB = 8'h0C;
   localparam logic [7:0] OFF_RXB = 8'h10;
   localparam logic [7:0] OFF_ISTAT = 8'h14;
   localparam logic [7:0] OFF_IMASK = 8'h18;
   // Control fields
   localparam int CTRL_W = 6;
   localparam int C_TXEN = 0;
   localparam int C_RXEN = 1;
   localparam int C_PAREN = 2;
   localparam int C_PARODD = 3;
   localparam int C_STOP2 = 4;
   localparam int C_BITS7 = 5;
   localparam logic [5:0] CTRL_RST = 6'h03;
   // Status fields
   localparam int S_TXE = 0;
   localparam int S_RXF = 1;
   localparam int S_ORUN = 2;
   localparam int S_FERR = 3;
   localparam int S_PERR = 4;
   localparam int S_TEND = 5;
   // Interrupt status and mask fields
   localparam int IRQ_W = 3;
   localparam int I_RXF = 0;
   localparam int I_TXE = 1;
   localparam int I_ERR = 2;
   // Sampling clock divider, core cycles per sixteenth of a bit
   localparam logic [15:0] DIV_RST = 16'h0082;
   localparam logic [15:0] DIV_MIN = 16'h0002;
   // Sampling phases: mid of start bit, then sixteen per bit
   localparam logic [3:0] SAMP_MID = 4'h7;
   localparam logic [3:0] SAMP_LAST = 4'hF;
   localparam logic [3:0] FRAME_MIN = 4'h9;
   localparam logic [3:0] FRAME_MAX = 4'hC;
   typedef enum logic [1:0] {
      RX_IDLE = 2'h0,
      RX_START = 2'h1,
      RX_DATA = 2'h3,
      RX_STOP = 2'h2
   } uartb_rx_e;
endpackage : uartb_pkg

// ---- hdl/uartb_samp_if.sv ----
// Interface: synchronised receive level and sampling clock phases.
// Driven by the synchroniser and the divider, read by the top level.
`timescale 1ns/1ps
interface uartb_samp_if;
   logic rxd_s;
   logic samp_rise;
   logic samp_fall;
   modport sync_src (output rxd_s);
   modport tick_src (output samp_rise, output samp_fall);
   modport sink (input rxd_s, input samp_rise, input samp_fall);
endinterface : uartb_samp_if

// ---- hdl/uartb_sync.sv ----
// Three-stage synchroniser for the receive pin with agreement filter.
// Assumes the pin is asynchronous to core_clk and idles high.
`timescale 1ns/1ps
module uartb_sync (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic pin_in,
   uartb_samp_if.sync_src samp
);
   typedef struct packed {
      logic [2:0] sh;
      logic lvl;
   } uartb_sync_s;
   uartb_sync_s q, d;

   always_comb begin
      d.sh = {q.sh[1:0], pin_in};
      // Level changes only when stages two and three agree
      d.lvl = (q.sh[1] == q.sh[2]) ? q.sh[2] : q.lvl;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '1;
      end else begin
         q <= d;
      end
   end

   assign samp.rxd_s = q.lvl;
endmodule : uartb_sync

// ---- hdl/uartb_top.sv ----
// Serial unit: transmit buffer, receive with error flags, AHB-Lite slave.
// Assumes a single AHB-Lite master, zero-wait answers, asynchronous rxd.
`timescale 1ns/1ps
module uartb_top (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [uartb_pkg::AW-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [uartb_pkg::HW-1:0] hwdata,
   input wire logic hready,
   output logic [uartb_pkg::HW-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic rxd,
   output logic txd,
   output logic irq,
   output logic rx_error_irq,
   output logic tx_empty_irq
);
   import uartb_pkg::*;

   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [HW-1:0] rdata;
      logic ready;
      logic resp;
      logic [CTRL_W-1:0] ctrl;
      logic [15:0] div;
      logic [IRQ_W-1:0] imask;
      logic [IRQ_W-1:0] istat;
      logic [7:0] txbuf;
      logic txe;
      logic tend;
      logic tx_busy;
      logic [11:0] tsh;
      logic [3:0] tbits;
      logic [3:0] tph;
      logic txd;
      uartb_rx_e rst;
      logic [3:0] rph;
      logic [3:0] rbit;
      logic [7:0] rx_shift_reg;
      logic rpar;
      logic rprev;
      logic brk;
      logic [7:0] rxbuf;
      logic rxf;
      logic orun;
      logic ferr;
      logic perr;
      logic irq;
      logic eirq;
      logic tirq;
   } uartb_st_s;
   uartb_st_s q, d;

   uartb_samp_if samp ();

   uartb_sync u_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .pin_in(rxd),
      .samp(samp)
   );

   uartb_baud u_baud (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .div(q.div),
      .samp(samp)
   );

   logic err, acc, rd_rxb, rd_ist, wr_txb, tx_load, rx_end, ov_c, fe_c, pe_c;
   logic par_c, bits7, paren;
   logic [3:0] nd, tot, last_bit;
   logic [11:0] fr;
   logic [5:0] stat_v;
   logic [HW-1:0] rd_v;

   always_comb begin
      err = q.orun | q.ferr | q.perr;
      bits7 = q.ctrl[C_BITS7];
      paren = q.ctrl[C_PAREN];
      nd = bits7 ? 4'h7 : 4'h8;
      last_bit = paren ? nd : nd - 4'h1;
      acc = hsel & htrans[1] & hready;
      rd_rxb = acc & ~hwrite & (haddr[7:0] == OFF_RXB);
      rd_ist = acc & ~hwrite & (haddr[7:0] == OFF_ISTAT);
      wr_txb = q.wr_pend & (q.wr_addr == OFF_TXB);
      // Load waits one cycle when a buffer write lands
      tx_load = ~q.txe & ~q.tx_busy & q.ctrl[C_TXEN] & ~err & ~wr_txb;
      par_c = (^(q.txbuf & (bits7 ? 8'h7F : 8'hFF))) ^ q.ctrl[C_PARODD];
      fr = {3'h7, q.txbuf, 1'h0};
      if (bits7) begin
         fr[8] = paren ? par_c : 1'h1;
      end else if (paren) begin
         fr[9] = par_c;
      end
      tot = 4'hA - {3'h0, bits7} + {3'h0, paren} + {3'h0, q.ctrl[C_STOP2]};
      rx_end = (q.rst == RX_STOP) & samp.samp_rise & (q.rph == SAMP_LAST);
      ov_c = q.rxf & ~rd_rxb;
      fe_c = ~samp.rxd_s;
      pe_c = paren & q.rpar;
      stat_v = '0;
      stat_v[S_TXE] = q.txe;
      stat_v[S_RXF] = q.rxf;
      stat_v[S_ORUN] = q.orun;
      stat_v[S_FERR] = q.ferr;
      stat_v[S_PERR] = q.perr;
      stat_v[S_TEND] = q.tend;
      case (haddr[7:0])
         OFF_CTRL: rd_v = {{(HW - CTRL_W){1'h0}}, q.ctrl};
         OFF_BAUD: rd_v = {16'h0000, q.div};
         OFF_STAT: rd_v = {26'h0, stat_v};
         OFF_TXB: rd_v = {24'h0, q.txbuf};
         OFF_RXB: rd_v = {24'h0, q.rxbuf};
         OFF_ISTAT: rd_v = {{(HW - IRQ_W){1'h0}}, q.istat};
         OFF_IMASK: rd_v = {{(HW - IRQ_W){1'h0}}, q.imask};
         default: rd_v = '0;
      endcase
   end

   always_comb begin
      d = q;
      d.tirq = 1'h0;
      d.ready = 1'h1;
      d.resp = 1'h0;
      // Bus: clears first so hardware sets below win
      d.wr_pend = acc & hwrite;
      d.wr_addr = haddr[7:0];
      if (acc & ~hwrite) begin
         d.rdata = rd_v;
      end
      if (rd_rxb) begin
         d.rxf = 1'h0;
      end
      if (rd_ist) begin
         d.istat = '0;
      end
      if (q.wr_pend) begin
         case (q.wr_addr)
            OFF_CTRL: d.ctrl = hwdata[CTRL_W-1:0];
            OFF_BAUD: d.div = hwdata[15:0];
            OFF_STAT: begin
               // Write one to clear an error flag
               if (hwdata[S_ORUN]) d.orun = 1'h0;
               if (hwdata[S_FERR]) d.ferr = 1'h0;
               if (hwdata[S_PERR]) d.perr = 1'h0;
            end
            OFF_TXB: begin
               d.txbuf = hwdata[7:0];
               d.txe = 1'h0;
               d.tend = 1'h0;
            end
            OFF_IMASK: d.imask = hwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
      // Transmitter
      if (tx_load) begin
         d.tsh = fr;
         d.tbits = tot;
         d.tph = 4'h0;
         d.tx_busy = 1'h1;
         d.txe = 1'h1;
         d.txd = 1'h0;
         d.tirq = 1'h1;
         d.istat[I_TXE] = 1'h1;
      end else if (q.tx_busy & samp.samp_rise) begin
         d.tph = q.tph + 4'h1;
         if (q.tph == SAMP_LAST) begin
            if (q.tbits == 4'h1) begin
               d.tx_busy = 1'h0;
               d.txd = 1'h1;
               d.tend = q.txe & ~wr_txb;
            end else begin
               d.tbits = q.tbits - 4'h1;
               d.tsh = {1'h1, q.tsh[11:1]};
               d.txd = q.tsh[1];
            end
         end
      end
      // Receiver
      if (samp.samp_fall) begin
         d.rprev = samp.rxd_s;
         if (samp.rxd_s) begin
            d.brk = 1'h0;
         end
      end
      if (samp.samp_rise) begin
         d.rph = q.rph + 4'h1;
      end
      unique case (q.rst)
         RX_IDLE: begin
            // Break keeps the receiver starting without a fresh edge
            if (q.ctrl[C_RXEN] & ~err & samp.samp_fall & ~samp.rxd_s
                & (q.rprev | q.brk)) begin
               d.rst = RX_START;
               d.rph = 4'h0;
               d.rx_shift_reg = 8'h00;
               d.rbit = 4'h0;
            end
         end
         RX_START: begin
            if (samp.samp_rise & (q.rph == SAMP_MID)) begin
               d.rph = 4'h0;
               d.rpar = q.ctrl[C_PARODD];
               d.rst = samp.rxd_s ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (samp.samp_rise & (q.rph == SAMP_LAST)) begin
               if (q.rbit < nd) begin
                  d.rx_shift_reg[q.rbit[2:0]] = samp.rxd_s;
               end
               d.rpar = q.rpar ^ samp.rxd_s;
               d.rbit = q.rbit + 4'h1;
               if (q.rbit == last_bit) begin
                  d.rst = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (rx_end) begin
               d.rst = RX_IDLE;
               d.brk = fe_c;
               d.ferr = d.ferr | fe_c;
               d.perr = d.perr | pe_c;
               if (ov_c) begin
                  d.orun = 1'h1;
                  d.istat[I_ERR] = 1'h1;
               end else begin
                  d.rxbuf = q.rx_shift_reg;
                  if (fe_c | pe_c) begin
                     d.istat[I_ERR] = 1'h1;
                  end else begin
                     d.rxf = 1'h1;
                     d.istat[I_RXF] = 1'h1;
                  end
               end
            end
         end
      endcase
      d.irq = |(d.istat & d.imask);
      d.eirq = d.orun | d.ferr | d.perr;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.ready <= 1'h1;
         q.ctrl <= CTRL_RST;
         q.div <= DIV_RST;
         q.txe <= 1'h1;
         q.tend <= 1'h1;
         q.txd <= 1'h1;
         q.rprev <= 1'h1;
      end else begin
         q <= d;
      end
   end

   assign hrdata = q.rdata;
   assign hreadyout = q.ready;
   assign hresp = q.resp;
   assign txd = q.txd;
   assign irq = q.irq;
   assign rx_error_irq = q.eirq;
   assign tx_empty_irq = q.tirq;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   a_txb_any_write: assert property (
      wr_txb |=> !q.txe && q.txbuf == $past(hwdata[7:0]))
      else $error("transmit buffer write not taken");
   a_txb_overwrite: assert property (
      wr_txb && !q.txe |=> !q.tx_busy || $past(q.tx_busy))
      else $error("pending byte sent before overwrite");
   a_txe_rise_irq: assert property (
      $rose(q.txe) |-> q.tirq && q.tx_busy && !q.txd)
      else $error("empty flag rise without load or interrupt");
   a_tx_frame_len: assert property (
      $rose(q.tx_busy) |-> q.tbits >= FRAME_MIN && q.tbits <= FRAME_MAX)
      else $error("frame length out of range");
   a_ovr_no_copy: assert property (
      rx_end && ov_c |=> q.orun && q.rxf && $stable(q.rxbuf))
      else $error("overrun handling wrong");
   a_ovr_all_flags: assert property (
      rx_end && ov_c |=> q.ferr == $past(fe_c) && q.perr == $past(pe_c))
      else $error("error flags not set with overrun");
   a_err_copy: assert property (
      rx_end && !ov_c && (fe_c || pe_c) |=> !q.rxf && q.rxbuf == $past(q.rx_shift_reg))
      else $error("errored byte not copied or full set");
   a_break_zero: assert property (
      rx_end && !ov_c && fe_c && q.rx_shift_reg == 8'h00 |=> q.ferr && q.rxbuf == 8'h00)
      else $error("break not flagged as zero byte");
   a_err_irq: assert property (
      $rose(q.ferr) || $rose(q.perr) || $rose(q.orun) |-> q.eirq && q.istat[I_ERR])
      else $error("error interrupt missing");
   a_err_suspend: assert property (
      err && q.rst == RX_IDLE && !q.tx_busy |=> q.rst == RX_IDLE && !q.tx_busy)
      else $error("activity while error flag set");
   a_start_on_fall: assert property (
      q.rst == RX_START && $past(q.rst) == RX_IDLE |-> $past(samp.samp_fall))
      else $error("start detected off falling phase");
   a_bit_mid_sample: assert property (
      $changed(q.rbit) && q.rst != RX_START
      |-> $past(samp.samp_rise) && $past(q.rph) == SAMP_LAST)
      else $error("bit sampled off its mid point");
   a_false_start: assert property (
      q.rst == RX_START && samp.samp_rise && q.rph == SAMP_MID && samp.rxd_s
      |=> q.rst == RX_IDLE)
      else $error("false start not dropped");
   // Start on a low level, break restart, error flags and error interrupt OR
   a_start_low: assert property (
      q.rst == RX_START && $past(q.rst) == RX_IDLE |-> !$past(samp.rxd_s))
      else $error("start detected on a high level");
   a_brk_restart: assert property (
      q.rst == RX_IDLE && q.brk && !err && q.ctrl[C_RXEN] && samp.samp_fall
      && !samp.rxd_s |=> q.rst == RX_START)
      else $error("receiver stopped during break");
   a_stop_low_ferr: assert property (
      rx_end && !samp.rxd_s |=> q.ferr)
      else $error("low stop bit not flagged");
   a_lone_parity: assert property (
      rx_end && !ov_c && pe_c && !fe_c |=> q.perr && !q.ferr && !q.orun)
      else $error("lone parity error set other flags");
   a_eirq_or: assert property (
      q.eirq == (q.orun || q.ferr || q.perr))
      else $error("error interrupt not the flag OR");

   c_overrun: cover property (rx_end && ov_c);
   c_break: cover property (rx_end && fe_c && q.rx_shift_reg == 8'h00);
   c_tx_load: cover property (tx_load);
   c_false_start: cover property (q.rst == RX_START ##1 q.rst == RX_IDLE);
   c_brk_restart: cover property (q.rst == RX_IDLE && q.brk && !err && samp.samp_fall);
endmodule : uartb_top
